// *** design/gsf_top.sv ***
// Sample buffer for three rate axes with register port and interrupts
`timescale 1ns/1ps
module gsf_top
  import gsf_pkg::*;
#(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned PW    = 5
)(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  input  wire logic       sample_clk_i,
  input  wire gsf_trip_t  sample_i,
  input  wire logic       trig_i,
  input  wire logic [6:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [6:0] next_addr_o,
  output logic            irq_pin_o,
  output logic            irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  function automatic logic [6:0] burst_next(input logic [6:0] a);
    burst_next = (a == ADDR_OUT_ZH) ? ADDR_OUT_XL : a + 7'h01;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Link sampling: two-flop synchronisers, then edge detect

  logic [SYNC_LEN-1:0] sclk_q;
  logic                sclk_d1_q;
  gsf_trip_t           smp_s1_q;
  gsf_trip_t           smp_s2_q;
  logic                new_smp;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sclk_q    <= '0;
      sclk_d1_q <= 1'b0;
      smp_s1_q  <= '0;
      smp_s2_q  <= '0;
    end
    else if (ce_i)
    begin
      sclk_q    <= {sclk_q[0], sample_clk_i};
      sclk_d1_q <= sclk_q[1];
      smp_s1_q  <= sample_i;
      smp_s2_q  <= smp_s1_q;
    end
  end

  assign new_smp = ce_i && sclk_q[1] && !sclk_d1_q;

  ////////////////////////////////////////////////////////////////////////
  // Control registers

  logic [7:0] ctrl_q;
  logic [2:0] irq_en_q;
  logic [2:0] mask_q;
  logic       trig_q;
  logic       wr_ctrl;
  gsf_mode_t  mode;
  gsf_mode_t  eff;
  logic [4:0] wtm;

  assign wr_ctrl = ce_i && wr_i && addr_i == ADDR_CTRL;
  assign mode    = gsf_mode_t'(ctrl_q[MODE_LSB +: 3]);
  assign wtm     = ctrl_q[WTM_LSB +: 5];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_q   <= CTRL_RST;
      irq_en_q <= EN_RST;
      mask_q   <= EN_RST;
    end
    else if (ce_i && wr_i)
    begin
      if (addr_i == ADDR_CTRL)
        ctrl_q <= wdata_i;
      if (addr_i == ADDR_IRQCFG)
        irq_en_q <= wdata_i[2:0];
      if (addr_i == ADDR_IMASK)
        mask_q <= wdata_i[2:0];
    end
  end

  // Trigger from the first interrupt generator; set wins over clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      trig_q <= 1'b0;
    else if (ce_i)
    begin
      if (trig_i && (mode == GSF_B2S || mode == GSF_S2F))
        trig_q <= 1'b1;
      else if (wr_ctrl)
        trig_q <= 1'b0;
    end
  end

  // Behaviour actually in force
  always_comb
  begin
    case (mode)
      GSF_BYPASS: eff = GSF_BYPASS;
      GSF_FIFO:   eff = GSF_FIFO;
      GSF_STREAM: eff = GSF_STREAM;
      GSF_S2F:    eff = trig_q ? GSF_FIFO : GSF_STREAM;
      GSF_B2S:    eff = trig_q ? GSF_STREAM : GSF_BYPASS;
      default:    eff = GSF_BYPASS;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Sample store, one slot holds all three axes

  gsf_trip_t         mem_q [DEPTH];
  logic [PW-1:0]     wp_q;
  logic [PW-1:0]     rp_q;
  logic [PW:0]       lvl_q;
  logic              full_c;
  logic              empty_c;
  logic              push;
  logic              pop;
  logic              byp;
  logic              halt_q;

  assign byp     = (eff == GSF_BYPASS);
  assign full_c  = (lvl_q == (PW+1)'(DEPTH));
  assign empty_c = (lvl_q == '0);
  assign push    = new_smp && !byp && !(eff == GSF_FIFO && (full_c || halt_q));
  assign pop     = ce_i && rd_i && addr_i == ADDR_OUT_XL && !byp && !empty_c;

  always_ff @(posedge clk_i)
  begin
    if (new_smp && byp)
      mem_q[0] <= smp_s2_q;
    else if (push)
      mem_q[wp_q] <= smp_s2_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wp_q  <= '0;
      rp_q  <= '0;
      lvl_q <= '0;
    end
    else if (ce_i)
    begin
      if (byp || (wr_ctrl && wdata_i[MODE_LSB +: 3] == GSF_BYPASS))
      begin
        wp_q  <= '0;
        rp_q  <= '0;
        lvl_q <= '0;
      end
      else
      begin
        if (push)
          wp_q <= ptr_inc(wp_q);
        if (pop || (push && full_c))
          rp_q <= ptr_inc(rp_q);
        if (push && !pop && !full_c)
          lvl_q <= lvl_q + (PW+1)'(1);
        else if (pop && !push)
          lvl_q <= lvl_q - (PW+1)'(1);
      end
    end
  end

  // A filled FIFO stays closed, even after reads, until bypass is written
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      halt_q <= 1'b0;
    else if (ce_i)
    begin
      if (eff == GSF_FIFO && full_c)
        halt_q <= 1'b1;
      else if (byp || (wr_ctrl && wdata_i[MODE_LSB +: 3] == GSF_BYPASS))
        halt_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Axis output registers

  gsf_trip_t out_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_q <= '0;
    else if (ce_i)
    begin
      if (byp && new_smp)
        out_q <= smp_s2_q;
      else if (pop)
        out_q <= mem_q[rp_q];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events and interrupts

  gsf_ev_t cond;
  gsf_ev_t cond_q;
  gsf_ev_t sts_q;
  logic    rd_sts;

  assign rd_sts = ce_i && rd_i && addr_i == ADDR_ISTS;

  // Live conditions behind the pin and the sticky bits
  always_comb
  begin
    cond.wtm   = !empty_c && lvl_q >= {1'b0, wtm};
    cond.full  = full_c;
    cond.empty = empty_c;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cond_q <= '0;
      sts_q  <= '0;
    end
    else if (ce_i)
    begin
      cond_q <= cond;
      sts_q  <= (rd_sts ? '0 : sts_q) | (cond & ~cond_q);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      irq_pin_o <= 1'b0;
      irq_o     <= 1'b0;
    end
    else if (ce_i)
    begin
      irq_pin_o <= |(cond & irq_en_q);
      irq_o     <= |(sts_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  gsf_trip_t rsrc;

  assign rsrc = pop ? mem_q[rp_q] : out_q;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rdata_o     <= '0;
      next_addr_o <= ADDR_OUT_XL;
    end
    else if (ce_i && (rd_i || wr_i))
    begin
      next_addr_o <= burst_next(addr_i);
      if (rd_i)
      begin
        case (addr_i)
          ADDR_OUT_XL:  rdata_o <= rsrc.x[7:0];
          ADDR_OUT_XH:  rdata_o <= out_q.x[15:8];
          ADDR_OUT_YL:  rdata_o <= out_q.y[7:0];
          ADDR_OUT_YH:  rdata_o <= out_q.y[15:8];
          ADDR_OUT_ZL:  rdata_o <= out_q.z[7:0];
          ADDR_OUT_ZH:  rdata_o <= out_q.z[15:8];
          ADDR_CTRL:    rdata_o <= ctrl_q;
          ADDR_SRC:     rdata_o <= {cond, lvl_q[4:0]};
          ADDR_IRQCFG:  rdata_o <= {5'h00, irq_en_q};
          ADDR_ISTS:    rdata_o <= {5'h00, sts_q};
          ADDR_IMASK:   rdata_o <= {5'h00, mask_q};
          default:      rdata_o <= 8'h00;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  sequence full_push_s;
    full_c && new_smp && !pop;
  endsequence

  fifo_full_hold_a: assert property (
    eff == GSF_FIFO && !wr_ctrl ##0 full_push_s |=> full_c && wp_q == $past(wp_q))
    else $error("full fifo took a sample");

  stream_drop_a: assert property (
    eff == GSF_STREAM && !wr_ctrl ##0 full_push_s |=> full_c && rp_q == ptr_inc($past(rp_q)))
    else $error("stream did not drop oldest");

  bypass_clear_a: assert property (
    wr_ctrl && wdata_i[MODE_LSB +: 3] == GSF_BYPASS |=> empty_c && rp_q == '0)
    else $error("bypass entry did not clear");

  bypass_live_a: assert property (
    byp && new_smp && !wr_ctrl |=> out_q == $past(smp_s2_q) && empty_c)
    else $error("bypass output not live");

  pop_triplet_a: assert property (
    pop |=> out_q == $past(mem_q[rp_q]) ##1 1'b1)
    else $error("pop moved wrong triplet");

  burst_wrap_a: assert property (
    ce_i && rd_i && addr_i == ADDR_OUT_ZH |=> next_addr_o == ADDR_OUT_XL)
    else $error("burst did not wrap");

  wtm_event_a: assert property (
    ce_i && cond.wtm && !cond_q.wtm |=> sts_q.wtm ##1 (irq_o || !$past(mask_q[EV_WTM])
      || !$past(ce_i)))
    else $error("watermark event lost");

  pin_enable_a: assert property (
    ce_i && |(cond & irq_en_q) |=> irq_pin_o)
    else $error("enabled event missed pin");

  src_report_a: assert property (
    ce_i && rd_i && addr_i == ADDR_SRC |=> rdata_o[7:5] == $past(cond))
    else $error("source register wrong");

  trig_switch_a: assert property (
    ce_i && trig_i && mode == GSF_B2S |=> eff == GSF_STREAM || mode != GSF_B2S)
    else $error("trigger did not start stream");

  trig_stop_a: assert property (
    ce_i && trig_i && mode == GSF_S2F |=> eff == GSF_FIFO || mode != GSF_S2F)
    else $error("trigger did not start fifo");

endmodule // gsf_top

// *** design/gsf_pkg.sv ***
// Constants, types and register map of the gyro sample buffer
// Summary of operation
// - The three rate axes share one store of 32 slots, each slot holding one triplet of sixteen-bit samples.
// - A mode field in the buffer control register picks one of five buffer modes.
// - Watermark, empty and full each have their own enable onto the shared irq pin.
// - The buffer source register shows the watermark, empty and full conditions.
// - Bits 4 to 0 of the buffer control register hold the watermark threshold.
// - Bypass keeps nothing: only the first slot is used and each sample overwrites it.
// - In FIFO mode samples are stored in order and the watermark fires at the threshold.
// - A full FIFO takes no more samples until software writes bypass mode again.
// - Stream mode keeps taking samples when full by dropping the oldest one.
// - Bypass-to-stream acts as bypass until a first-generator event, then as stream.
// - Stream-to-FIFO acts as stream until a first-generator event, then as FIFO.
// - Outside bypass, reads of the axis outputs return buffered data, not live data.
// - Each buffer read moves the oldest triplet of all three axes to the outputs at once.
// - Reads may be single or bursts whose address wraps from Z high back to X low.
// - Rate outputs are signed, counterclockwise rotation giving a positive value.
package gsf_pkg;

  // Register addresses
  localparam logic [6:0] ADDR_IRQCFG = 7'h22;
  localparam logic [6:0] ADDR_OUT_XL = 7'h28;
  localparam logic [6:0] ADDR_OUT_XH = 7'h29;
  localparam logic [6:0] ADDR_OUT_YL = 7'h2a;
  localparam logic [6:0] ADDR_OUT_YH = 7'h2b;
  localparam logic [6:0] ADDR_OUT_ZL = 7'h2c;
  localparam logic [6:0] ADDR_OUT_ZH = 7'h2d;
  localparam logic [6:0] ADDR_CTRL   = 7'h2e;
  localparam logic [6:0] ADDR_SRC    = 7'h2f;
  localparam logic [6:0] ADDR_ISTS   = 7'h30;
  localparam logic [6:0] ADDR_IMASK  = 7'h31;

  // Field positions and reset values
  localparam int unsigned WTM_LSB   = 0;
  localparam int unsigned MODE_LSB  = 5;
  localparam int unsigned EV_EMPTY  = 0;
  localparam int unsigned EV_FULL   = 1;
  localparam int unsigned EV_WTM    = 2;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam logic [2:0]  EN_RST    = 3'h0;
  localparam int unsigned SYNC_LEN  = 2;

  typedef enum logic [2:0] {
    GSF_BYPASS = 3'b000,
    GSF_FIFO   = 3'b001,
    GSF_STREAM = 3'b010,
    GSF_S2F    = 3'b011,
    GSF_B2S    = 3'b100
  } gsf_mode_t;

  typedef struct packed {
    logic signed [15:0] z;
    logic signed [15:0] y;
    logic signed [15:0] x;
  } gsf_trip_t;

  typedef struct packed {
    logic wtm;
    logic full;
    logic empty;
  } gsf_ev_t;

endpackage

// *** tb/gsf_sense_model.sv ***
// Sensor core model: paced link clock and sample stream
`timescale 1ns/1ps
module gsf_sense_model
  import gsf_pkg::*;
(
  input  wire logic en_i,
  output logic      sclk_o,
  output gsf_trip_t smp_o,
  output int        cnt_o
);
  function automatic gsf_trip_t val(input int k);
    val.x = 16'(k * 273);
    val.y = -val.x;
    val.z = 16'(k) ^ 16'h8000;
  endfunction

  // Clock stands still while idle; data moves only on the falling edge
  initial
  begin
    sclk_o = 1'b0;
    cnt_o = 0;
    smp_o = val(1);
    forever
    begin
      wait (en_i);
      #62.5;
      if (en_i)
      begin
        sclk_o = 1'b1;
        #62.5;
        sclk_o = 1'b0;
        cnt_o = cnt_o + 1;
        smp_o = val(cnt_o + 1);
      end
    end
  end
endmodule // gsf_sense_model

// *** tb/gyro_sample_fifo_tb_top.sv ***
// Self-checking bench for the gyro sample buffer
`timescale 1ns/1ps
module gyro_sample_fifo_tb_top;
  import gsf_pkg::*;
  logic       clk_i = 0;
  logic       rst_i = 1;
  logic       trig_i = 0;
  logic       wr_i = 0;
  logic       rd_i = 0;
  logic       en = 0;
  logic       ce = 1;
  logic [6:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic [7:0] rdata_o;
  logic [6:0] next_addr_o;
  logic       irq_pin_o;
  logic       irq_o;
  logic       sclk;
  gsf_trip_t  smp;
  int         cnt;
  int         base;
  int         cyc = 0;
  int         err_count = 0;
  int         total_checks = 0;

  gsf_sense_model core (.en_i(en), .sclk_o(sclk), .smp_o(smp), .cnt_o(cnt));
  gsf_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .sample_clk_i(sclk),
    .sample_i(smp), .trig_i(trig_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .next_addr_o(next_addr_o), .irq_pin_o(irq_pin_o),
    .irq_o(irq_o));

  always #2 clk_i = ~clk_i;

  always @(posedge clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_count++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (err_count == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(logic [6:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(logic [6:0] a, logic [7:0] exp, bit ck = 1);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    if (ck)
      chk("rdata", 16'(rdata_o), 16'(exp));
  endtask

  function automatic gsf_trip_t val(input int k);
    val.x = 16'(k * 273);
    val.y = -val.x;
    val.z = 16'(k) ^ 16'h8000;
  endfunction

  // Reads one triplet in burst order, X low byte first
  task automatic pop(int k);
    logic [47:0] b = val(k);
    for (int i = 0; i < 6; i++)
      rd(7'(ADDR_OUT_XL + i), b[8*i +: 8]);
    chk("next_addr", 16'(next_addr_o), 16'(ADDR_OUT_XL));
  endtask

  task automatic push(int n);
    int t = cnt + n;
    en = 1'b1;
    for (int i = 0; i < 200 * n && cnt < t; i++)
      @(posedge clk_i);
    en = 1'b0;
    repeat (8) @(posedge clk_i);
    #1;
  endtask

  task automatic pulse();
    @(posedge clk_i);
    trig_i <= 1'b1;
    @(posedge clk_i);
    trig_i <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_SRC, 8'h20);
    rd(7'h50, 8'h00);
    // Clock enable low: a write is not taken
    @(posedge clk_i);
    ce <= 1'b0;
    wr(ADDR_CTRL, 8'h24);
    ce <= 1'b1;
    rd(ADDR_CTRL, CTRL_RST);
    wr(ADDR_SRC, 8'hff);
    rd(ADDR_SRC, 8'h20);
    // Bypass: live data, nothing kept
    push(3);
    rd(ADDR_SRC, 8'h20);
    pop(cnt);
    wr(ADDR_IRQCFG, 8'h01);
    rd(ADDR_IRQCFG, 8'h01);
    chk("irq_pin", 16'(irq_pin_o), 16'h1);
    for (int m = 5; m < 8; m++)
    begin
      wr(ADDR_CTRL, 8'(m << 5));
      push(1);
      rd(ADDR_SRC, 8'h20);
    end
    // FIFO with watermark 4
    wr(ADDR_CTRL, 8'h24);
    wr(ADDR_IRQCFG, 8'h04);
    wr(ADDR_IMASK, 8'h04);
    rd(ADDR_ISTS, 8'h00, 0);
    base = cnt;
    push(3);
    chk("irq_pin", 16'(irq_pin_o), 16'h0);
    rd(ADDR_SRC, 8'h03);
    push(1);
    chk("irq_pin", 16'(irq_pin_o), 16'h1);
    chk("irq", 16'(irq_o), 16'h1);
    rd(ADDR_SRC, 8'h84);
    rd(ADDR_ISTS, 8'h04);
    @(posedge clk_i);
    #1 chk("irq", 16'(irq_o), 16'h0);
    push(30);
    chk("irq", 16'(irq_o), 16'h0);
    rd(ADDR_SRC, 8'hc0);
    wr(ADDR_IRQCFG, 8'h02);
    rd(ADDR_IRQCFG, 8'h02);
    chk("irq_pin", 16'(irq_pin_o), 16'h1);
    pop(base + 1);
    rd(ADDR_SRC, 8'h9f);
    push(1);
    rd(ADDR_SRC, 8'h9f);
    wr(ADDR_CTRL, 8'h04);
    rd(ADDR_SRC, 8'h20);
    // Stream drops the oldest
    wr(ADDR_CTRL, 8'h44);
    base = cnt;
    push(34);
    rd(ADDR_SRC, 8'hc0);
    pop(base + 3);
    // Stream then FIFO after trigger
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_CTRL, 8'h64);
    base = cnt;
    push(34);
    pulse();
    push(2);
    pop(base + 3);
    rd(ADDR_SRC, 8'h9f);
    // Bypass then stream after trigger
    wr(ADDR_CTRL, 8'h04);
    wr(ADDR_CTRL, 8'h84);
    push(3);
    rd(ADDR_SRC, 8'h20);
    base = cnt;
    pulse();
    push(2);
    rd(ADDR_SRC, 8'h02);
    pop(base + 1);
    wrap_up();
  end
endmodule // gyro_sample_fifo_tb_top
